// ==== tb_top.sv ====
// self-checking bench for the torque reference conditioner
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic st, di, tm, run, tlf, slf, trf;
	logic signed [15:0] tr, av, ac, spd, tro;
	logic [15:0] slo;
	int err_count, compares, i;
	logic [15:0] rst_tab [14] = '{16'hc8, 16'h118, 16'h0, 16'hbb8, 16'hbb8, 16'hbb8, 16'hbb8,
		16'h3e8, 16'h3e8, 16'hbb8, 16'hbb8, 16'h0, 16'hc8, 16'h64};
	logic signed [15:0] rch_ref [5] = '{16'sd50, 16'sd150, 16'sd200, 16'sd150, 16'sd100};
	logic rch_exp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	trc_host_model host (.clk(clk), .sample_tick(st), .torque_ref(tr), .volt_in(av),
		.curr_in(ac), .speed(spd), .ext_sel(di), .tq_mode(tm), .running(run));
	trc_conditioner uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_tick(st), .torque_ref_in(tr), .analog_voltage_input(av),
		.analog_current_input(ac), .motor_speed(spd), .external_limit_select_input(di),
		.torque_mode(tm), .drive_running(run), .torque_ref_out(tro), .speed_limit_out(slo),
		.torque_limited_flag(tlf), .speed_limited_flag(slf), .torque_reached_flag(trf));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [7:0] ad(input logic [3:0] ix);
		return {2'b00, ix, 2'b00};
	endfunction : ad
	task automatic final_report();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			err_count++;
			final_report();
		end
	endtask : xfer
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = 44'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 14; i++) begin
			xfer(0, ad(4'(i)), 0);
			chk("reset value", rst_tab[i], rd[15:0]);
		end
		xfer(0, 8'h40, 0);
		chk("unmapped", 16'h1, {15'h0, rerr});
		xfer(1, ad(trc_pkg::IX_F1_FC), 32'h4e20);
		xfer(0, ad(trc_pkg::IX_F1_FC), 0);
		chk("cutoff max", 16'h3e80, rd[15:0]);
		xfer(1, ad(trc_pkg::IX_F2_FC), 32'h1);
		xfer(0, ad(trc_pkg::IX_F2_FC), 0);
		chk("cutoff min", 16'h0005, rd[15:0]);
		xfer(1, ad(trc_pkg::IX_CTRL), 32'h0f);
		host.step(16'sd1000, 0, 0, 0, 0, 1, 0);
		chk("slow filter", 16'h1, {15'h0, tro < 16'sd100});
		xfer(1, ad(trc_pkg::IX_CTRL), 32'h0e);
		host.step(16'sd1000, 0, 0, 0, 0, 0, 0);
		chk("fast filter", 16'd1000, tro);
		xfer(1, ad(trc_pkg::IX_INT_POS), 32'h3e8);
		host.step(16'sd1500, 0, 0, 0, 0, 0, 0);
		chk("clamp", 16'd1000, tro);
		chk("limited", 16'h1, {15'h0, tlf});
		host.step(-16'sd500, 0, 0, 0, 0, 0, 0);
		chk("pass", 16'hfe0c, tro);
		chk("not limited", 16'h0, {15'h0, tlf});
		xfer(1, ad(trc_pkg::IX_INT_POS), 32'hfa0);
		host.step(16'sd3500, 0, 0, 0, 0, 0, 0);
		chk("ceiling", 16'd3000, tro);
		xfer(1, ad(trc_pkg::IX_INT_POS), 32'h3e8);
		for (i = 0; i < 5; i++) begin
			host.step(rch_ref[i], 0, 0, 0, 0, 0, 0);
			chk("reached", {15'h0, rch_exp[i]}, {15'h0, trf});
		end
		xfer(1, ad(trc_pkg::IX_SRC), 32'h1);
		xfer(1, ad(trc_pkg::IX_EXT_FWD), 32'h1f4);
		host.step(16'sd1500, 0, 0, 0, 1, 0, 0);
		chk("external on", 16'd500, tro);
		host.step(16'sd1500, 0, 0, 0, 0, 0, 0);
		chk("external off", 16'd1000, tro);
		xfer(1, ad(trc_pkg::IX_SRC), 32'h2);
		host.step(16'sd800, -16'sd5000, 0, 0, 0, 0, 0);
		chk("voltage limit", 16'd500, tro);
		xfer(1, ad(trc_pkg::IX_SRC), 32'h3);
		xfer(1, ad(trc_pkg::IX_AC_SC), 32'h7d0);
		host.step(16'sd1200, 0, 16'sd10000, 0, 0, 0, 1);
		chk("current limit", 16'd1000, tro);
		xfer(0, ad(trc_pkg::IX_STAT), 0);
		chk("status torque", 16'd1000, rd[31:16]);
		chk("status flags", 16'h0005, rd[15:0]);
		xfer(1, ad(trc_pkg::IX_SRC), 32'h0);
		xfer(0, ad(trc_pkg::IX_SRC), 0);
		chk("source locked", 16'h3, rd[15:0]);
		host.step(0, 0, 16'sd10000, 16'sd3001, 0, 1, 1);
		chk("over speed", 16'h1, {15'h0, slf});
		chk("speed limit", 16'd3000, slo);
		host.step(0, 0, 16'sd10000, 16'sd3000, 0, 1, 1);
		chk("at speed", 16'h0, {15'h0, slf});
		xfer(1, ad(trc_pkg::IX_SPD_NEG), 32'h3e8);
		host.step(0, 0, 16'sd10000, -16'sd1001, 0, 1, 1);
		chk("reverse over", 16'h1, {15'h0, slf});
		chk("reverse limit", 16'd1000, slo);
		host.step(0, 0, 16'sd10000, 16'sd5000, 0, 0, 1);
		chk("speed mode", 16'h0, {15'h0, slf});
		xfer(1, ad(trc_pkg::IX_CTRL), 32'h7e);
		host.step(0, 0, 16'sd10000, 0, 0, 0, 1);
		chk("inverted limit", 16'h1, {15'h0, tlf});
		chk("inverted speed", 16'h1, {15'h0, slf});
		chk("inverted reached", 16'h1, {15'h0, trf});
		final_report();
	end
endmodule : tb_top

// ==== trc_conditioner.sv ====
// torque reference filter, limiter, speed limit and status flag logic with apb registers

// Function
// R01 - two filters, first unless second selected
// R02 - first cutoff 5..16000 Hz, default 200
// R03 - second cutoff same range, default 280
// R04 - filtering applies in every control mode
// R05 - clamp reference to limit when exceeding
// R06 - limits capped at 300.0% rated torque
// R07 - exactly one limit set active
// R08 - source 0..3, changed only when stopped
// R09 - source 0 uses internal limits
// R10 - source 1: external limits while input active
// R11 - source 2: voltage input times scale
// R12 - source 3: current input times scale
// R13 - limit words 0..4000, default 3000
// R14 - torque limited flag while clamping
// R15 - torque mode speed limit by direction
// R16 - speed limited flag in torque mode
// R17 - reached sets at base plus set offset
// R18 - reached clears at base plus clear offset
// R19 - reached words 0..4000, defaults 0/200/100
// R20 - flags leave via assignable polarity outputs
// R21 - analog torque is mV/10000 times scale
// R22 - signed 0.1% values, abs comparisons
// R23 - update per sample tick, limit after filter
module trc_conditioner (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	// apb slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [trc_pkg::ADR_W-1:0]        paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// control loop inputs
	input  wire logic                             sample_tick,
	input  wire logic signed [15:0]               torque_ref_in,
	input  wire logic signed [15:0]               analog_voltage_input,
	input  wire logic signed [15:0]               analog_current_input,
	input  wire logic signed [15:0]               motor_speed,
	input  wire logic                             external_limit_select_input,
	input  wire logic                             torque_mode,
	input  wire logic                             drive_running,
	// conditioned outputs
	output logic signed [15:0]                    torque_ref_out,
	output logic      [15:0]                      speed_limit_out,
	// digital outputs
	output logic                                  torque_limited_flag,
	output logic                                  speed_limited_flag,
	output logic                                  torque_reached_flag
);

	typedef struct packed {
		logic [trc_pkg::NPRM-1:0][15:0] prm;
		logic [15:0]                    ctrl;
		logic signed [31:0]             acc1;
		logic signed [31:0]             acc2;
		logic signed [15:0]             tq_out;
		logic [15:0]                    spd_lim;
		logic                           tq_lim;
		logic                           spd_limd;
		logic                           tq_rch;
		logic                           do_lim;
		logic                           do_spd;
		logic                           do_rch;
		logic [31:0]                    prdata;
		logic                           pready;
		logic                           pslverr;
	} trc_state_s;

	trc_state_s q_ff;
	trc_state_s nxt_q;

	// magnitude of a signed word
	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		abs16 = v[15] ? 16'(-v) : 16'(v);
	endfunction : abs16

	// one first-order low-pass step, state in Q16
	function automatic logic signed [31:0] filt_step(input logic signed [31:0] acc,
			input logic signed [15:0] x, input logic [15:0] fc);
		logic [31:0]        a;
		logic signed [63:0] d;
		a = 32'(fc) * trc_pkg::ALPHA_PER_HZ;
		if (a > trc_pkg::ALPHA_ONE)
			a = trc_pkg::ALPHA_ONE;
		d = (64'(x) <<< trc_pkg::FRAC) - 64'(acc);
		d = (d * $signed({32'h0, a})) >>> trc_pkg::ALPHA_SHIFT;
		filt_step = acc + 32'(d);
	endfunction : filt_step

	// analog input scaled to a limit magnitude, capped at the ceiling
	function automatic logic [15:0] ai_lim(input logic signed [15:0] v,
			input logic [15:0] sc, input logic [31:0] full);
		logic [47:0] p;
		p = (48'(abs16(v)) * 48'(sc)) / 48'(full);
		ai_lim = (p > 48'(trc_pkg::LIM_CEIL)) ? trc_pkg::LIM_CEIL : 16'(p);
	endfunction : ai_lim

	// cap a limit word at the rated ceiling
	function automatic logic [15:0] ceil_lim(input logic [15:0] v);
		ceil_lim = (v > trc_pkg::LIM_CEIL) ? trc_pkg::LIM_CEIL : v;
	endfunction : ceil_lim

	logic                   mapped;
	logic [3:0]             ix;
	logic signed [15:0]     filt;
	logic [15:0]            lim_pos;
	logic [15:0]            lim_neg;
	logic [15:0]            mag;
	logic [16:0]            thr_set;
	logic [16:0]            thr_clr;
	trc_pkg::trc_src_e      src;

	always_comb begin
		nxt_q   = q_ff;
		ix      = paddr[5:2];
		mapped  = (paddr[1:0] == 2'b00) && (paddr[trc_pkg::ADR_W-1:6] == '0);
		src     = trc_pkg::trc_src_e'(q_ff.prm[trc_pkg::IX_SRC][1:0]);
		filt    = '0;
		lim_pos = '0;
		lim_neg = '0;
		mag     = '0;
		thr_set = '0;
		thr_clr = '0;

		// setup phase: decode and latch the answer for the access phase
		if (psel && !penable) begin
			nxt_q.pslverr = !mapped;
			if (!mapped)
				nxt_q.prdata = '0;
			else if (ix == trc_pkg::IX_CTRL)
				nxt_q.prdata = {16'h0, q_ff.ctrl};
			else if (ix == trc_pkg::IX_STAT)
				nxt_q.prdata = {q_ff.tq_out, 13'h0, q_ff.tq_rch, q_ff.spd_limd, q_ff.tq_lim};
			else
				nxt_q.prdata = {16'h0, q_ff.prm[ix]};
		end

		// access phase write; ranges saturate on write
		if (psel && penable && pwrite && mapped) begin
			if (ix == trc_pkg::IX_CTRL) begin
				nxt_q.ctrl = pwdata[15:0] & trc_pkg::CTRL_MASK;
			end else if (ix == trc_pkg::IX_SRC) begin
				if (!drive_running)  // see R08
					nxt_q.prm[ix] = trc_pkg::prm_sat(ix, pwdata[15:0]);
			end else if (ix != trc_pkg::IX_STAT) begin
				nxt_q.prm[ix] = trc_pkg::prm_sat(ix, pwdata[15:0]);  // see R02 see R13 see R19
			end
		end

		if (sample_tick) begin
			// both filters always run so a switch is bumpless
			nxt_q.acc1 = filt_step(q_ff.acc1, torque_ref_in,
				q_ff.prm[trc_pkg::IX_F1_FC]);  // see R01 see R04
			nxt_q.acc2 = filt_step(q_ff.acc2, torque_ref_in,
				q_ff.prm[trc_pkg::IX_F2_FC]);  // see R03
			filt = q_ff.ctrl[trc_pkg::CT_FSEL] ? 16'(nxt_q.acc2 >>> trc_pkg::FRAC)
				: 16'(nxt_q.acc1 >>> trc_pkg::FRAC);  // see R01 see R23

			// one limit pair chosen by the source word
			unique case (src)  // see R07
				trc_pkg::SRC_INTERNAL: begin
					lim_pos = q_ff.prm[trc_pkg::IX_INT_POS];  // see R09
					lim_neg = q_ff.prm[trc_pkg::IX_INT_NEG];
				end
				trc_pkg::SRC_EXTERNAL: begin
					if (external_limit_select_input) begin  // see R10
						lim_pos = q_ff.prm[trc_pkg::IX_EXT_FWD];
						lim_neg = q_ff.prm[trc_pkg::IX_EXT_REV];
					end else begin
						lim_pos = q_ff.prm[trc_pkg::IX_INT_POS];
						lim_neg = q_ff.prm[trc_pkg::IX_INT_NEG];
					end
				end
				trc_pkg::SRC_AI_VOLT: begin
					lim_pos = ai_lim(analog_voltage_input,
						q_ff.prm[trc_pkg::IX_AV_SC], trc_pkg::AV_FULL);  // see R11 see R21
					lim_neg = lim_pos;
				end
				trc_pkg::SRC_AI_CURR: begin
					lim_pos = ai_lim(analog_current_input,
						q_ff.prm[trc_pkg::IX_AC_SC], trc_pkg::AC_FULL);  // see R12
					lim_neg = lim_pos;
				end
			endcase
			lim_pos = ceil_lim(lim_pos);  // see R06
			lim_neg = ceil_lim(lim_neg);

			// clamp after filtering, signed compare in 17 bits
			if (17'(filt) >= $signed({1'b0, lim_pos})) begin  // see R05 see R22
				nxt_q.tq_out = $signed(lim_pos);
				nxt_q.tq_lim = 1'b1;  // see R14
			end else if (17'(filt) <= -$signed({1'b0, lim_neg})) begin
				nxt_q.tq_out = -$signed(lim_neg);
				nxt_q.tq_lim = 1'b1;
			end else begin
				nxt_q.tq_out = filt;
				nxt_q.tq_lim = 1'b0;
			end

			// speed limit picked by rotation direction
			if (motor_speed[15]) begin  // see R15
				nxt_q.spd_lim  = q_ff.prm[trc_pkg::IX_SPD_NEG];
				nxt_q.spd_limd = torque_mode &&
					(abs16(motor_speed) > q_ff.prm[trc_pkg::IX_SPD_NEG]);  // see R16
			end else begin
				nxt_q.spd_lim  = q_ff.prm[trc_pkg::IX_SPD_POS];
				nxt_q.spd_limd = torque_mode &&
					(abs16(motor_speed) > q_ff.prm[trc_pkg::IX_SPD_POS]);
			end

			// reached with hysteresis on the output magnitude
			mag     = abs16(nxt_q.tq_out);
			thr_set = 17'(q_ff.prm[trc_pkg::IX_TR_BASE]) + 17'(q_ff.prm[trc_pkg::IX_TR_SET]);
			thr_clr = 17'(q_ff.prm[trc_pkg::IX_TR_BASE]) + 17'(q_ff.prm[trc_pkg::IX_TR_CLR]);
			if (17'(mag) >= thr_set)
				nxt_q.tq_rch = 1'b1;  // see R17
			else if (17'(mag) <= thr_clr)
				nxt_q.tq_rch = 1'b0;  // see R18
		end

		// unassigned output rests at its inactive level
		nxt_q.do_lim = (nxt_q.tq_lim & q_ff.ctrl[trc_pkg::CT_EN_LIM])
			^ q_ff.ctrl[trc_pkg::CT_INV_LIM];  // see R20
		nxt_q.do_spd = (nxt_q.spd_limd & q_ff.ctrl[trc_pkg::CT_EN_SPD])
			^ q_ff.ctrl[trc_pkg::CT_INV_SPD];
		nxt_q.do_rch = (nxt_q.tq_rch & q_ff.ctrl[trc_pkg::CT_EN_RCH])
			^ q_ff.ctrl[trc_pkg::CT_INV_RCH];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_ff        <= '0;
			q_ff.prm    <= trc_pkg::PRM_RST;
			q_ff.pready <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign prdata              = q_ff.prdata;
	assign pready              = q_ff.pready;
	assign pslverr             = q_ff.pslverr;
	assign torque_ref_out      = q_ff.tq_out;
	assign speed_limit_out     = q_ff.spd_lim;
	assign torque_limited_flag = q_ff.do_lim;
	assign speed_limited_flag  = q_ff.do_spd;
	assign torque_reached_flag = q_ff.do_rch;

endmodule : trc_conditioner

// ==== trc_conditioner_chk.sv ====
// port assertions of the torque reference conditioner
module trc_conditioner_chk (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       rst_n,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [trc_pkg::ADR_W-1:0]  paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// loop
	input wire logic                       sample_tick,
	input wire logic                       torque_mode,
	input wire logic signed [15:0]         torque_ref_out,
	input wire logic                       torque_limited_flag,
	input wire logic                       speed_limited_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] ctrl_ff;
	wire        ctl_wr = psel && penable && pwrite && paddr == 8'h38;
	wire        rd_acc = psel && penable && !pwrite;
	wire        setup  = psel && !penable;
	// shadow of the output control word
	always_ff @(posedge clk) begin
		if (!rst_n) ctrl_ff <= 7'h00;
		else if (ctl_wr) ctrl_ff <= pwdata[6:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	pready_up_a: assert property (pready) else $error("pready low");
	bad_addr_a: assert property (setup && (paddr[1:0] != 2'b00 || paddr >= 8'h40)
		|=> pslverr) else $error("no error on bad address");
	good_addr_a: assert property (setup && paddr[1:0] == 2'b00 && paddr < 8'h40
		|=> !pslverr) else $error("error on good address");
	out_hold_a: assert property (!sample_tick |=> $stable(torque_ref_out))
		else $error("output moved without tick");
	lim_ceil_a: assert property (sample_tick |=> torque_ref_out <= 16'sd3000
		&& torque_ref_out >= -16'sd3000) else $error("limit ceiling exceeded");
	spd_mode_a: assert property (sample_tick && !torque_mode
		|=> speed_limited_flag == $past(ctrl_ff[5])) else $error("speed flag outside mode");
	lim_off_a: assert property (!ctrl_ff[1] |=> torque_limited_flag == $past(ctrl_ff[4]))
		else $error("disabled output not idle");
	flag_hold_a: assert property (!sample_tick && $stable(ctrl_ff)
		|=> $stable(torque_limited_flag)) else $error("flag moved without tick");
	stat_word_a: assert property (rd_acc && paddr == 8'h3c
		|-> prdata[31:16] == $past(torque_ref_out)) else $error("status word wrong");
	upper_zero_a: assert property (rd_acc && paddr < 8'h38 |-> prdata[31:16] == 16'h0000)
		else $error("upper bits set");
	cover property (sample_tick);
	cover property (setup ##1 pslverr);
	cover property ($rose(torque_limited_flag));
endmodule : trc_conditioner_chk

bind trc_conditioner trc_conditioner_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sample_tick(sample_tick), .torque_mode(torque_mode),
	.torque_ref_out(torque_ref_out), .torque_limited_flag(torque_limited_flag),
	.speed_limited_flag(speed_limited_flag));

// ==== trc_host_model.sv ====
// host controller model driving the loop inputs, speed included
module trc_host_model (
	// clock
	input  wire logic         clk,
	// loop inputs of the conditioner
	output logic              sample_tick,
	output logic signed [15:0] torque_ref,
	output logic signed [15:0] volt_in,
	output logic signed [15:0] curr_in,
	output logic signed [15:0] speed,
	output logic              ext_sel,
	output logic              tq_mode,
	output logic              running
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{sample_tick, ext_sel, tq_mode, running} = 4'h0;
		{torque_ref, volt_in, curr_in, speed} = 64'h0;
	end
	// present one sample and let the result settle
	task automatic step(input logic signed [15:0] r, v, c, s, input logic d, m, u);
		@(posedge clk);
		torque_ref <= r;
		volt_in <= v;
		curr_in <= c;
		speed <= s;
		{ext_sel, tq_mode, running} <= {d, m, u};
		sample_tick <= 1'b1;
		@(posedge clk);
		sample_tick <= 1'b0;
		#1;
	endtask : step
endmodule : trc_host_model

// ==== trc_pkg.sv ====
// constants, register map and parameter ranges of the torque reference conditioner
package trc_pkg;

	localparam int          NPRM  = 14;
	localparam int          ADR_W = 8;

	// register word indices; byte address is index times four
	localparam logic [3:0]  IX_F1_FC   = 4'h0;
	localparam logic [3:0]  IX_F2_FC   = 4'h1;
	localparam logic [3:0]  IX_SRC     = 4'h2;
	localparam logic [3:0]  IX_INT_POS = 4'h3;
	localparam logic [3:0]  IX_INT_NEG = 4'h4;
	localparam logic [3:0]  IX_EXT_FWD = 4'h5;
	localparam logic [3:0]  IX_EXT_REV = 4'h6;
	localparam logic [3:0]  IX_AV_SC   = 4'h7;
	localparam logic [3:0]  IX_AC_SC   = 4'h8;
	localparam logic [3:0]  IX_SPD_POS = 4'h9;
	localparam logic [3:0]  IX_SPD_NEG = 4'ha;
	localparam logic [3:0]  IX_TR_BASE = 4'hb;
	localparam logic [3:0]  IX_TR_SET  = 4'hc;
	localparam logic [3:0]  IX_TR_CLR  = 4'hd;
	localparam logic [3:0]  IX_CTRL    = 4'he;
	localparam logic [3:0]  IX_STAT    = 4'hf;

	// parameter reset values, index 13 down to 0
	localparam logic [NPRM-1:0][15:0] PRM_RST = {
		16'h0064, 16'h00c8, 16'h0000, 16'h0bb8, 16'h0bb8, 16'h03e8, 16'h03e8,
		16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h0000, 16'h0118, 16'h00c8};

	// parameter ranges
	localparam logic [15:0] FC_MIN     = 16'h0005;
	localparam logic [15:0] FC_MAX     = 16'h3e80;
	localparam logic [15:0] SRC_MAX    = 16'h0003;
	localparam logic [15:0] TQ_MAX     = 16'h0fa0;
	localparam logic [15:0] SC_MAX     = 16'h1f40;
	localparam logic [15:0] SPD_MAX    = 16'h1f40;
	localparam logic [15:0] LIM_CEIL   = 16'h0bb8;

	// control register fields
	localparam int          CT_FSEL    = 0;
	localparam int          CT_EN_LIM  = 1;
	localparam int          CT_EN_SPD  = 2;
	localparam int          CT_EN_RCH  = 3;
	localparam int          CT_INV_LIM = 4;
	localparam int          CT_INV_SPD = 5;
	localparam int          CT_INV_RCH = 6;
	localparam logic [15:0] CTRL_MASK  = 16'h007f;

	// status register fields
	localparam int          ST_LIM     = 0;
	localparam int          ST_SPD     = 1;
	localparam int          ST_RCH     = 2;

	// analog full scale: millivolts at 10 V, microamps at 20 mA
	localparam logic [31:0] AV_FULL    = 32'h0000_2710;
	localparam logic [31:0] AC_FULL    = 32'h0000_4e20;

	// filter: alpha = 2*pi*fc/fs in Q20, one update per sample tick
	localparam int          SAMPLE_HZ   = 32000;
	localparam int          ALPHA_SHIFT = 20;
	localparam int          FRAC        = 16;
	localparam logic [31:0] TWO_PI_Q20  = 32'h0064_87ed;
	localparam logic [31:0] ALPHA_PER_HZ = TWO_PI_Q20 / 32'(SAMPLE_HZ);
	localparam logic [31:0] ALPHA_ONE   = 32'h0010_0000;

	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_EXTERNAL,
		SRC_AI_VOLT,
		SRC_AI_CURR
	} trc_src_e;

	// largest legal value of a parameter word
	function automatic logic [15:0] prm_max(input logic [3:0] ix);
		unique case (ix)
			IX_F1_FC, IX_F2_FC:     prm_max = FC_MAX;
			IX_SRC:                 prm_max = SRC_MAX;
			IX_AV_SC, IX_AC_SC:     prm_max = SC_MAX;
			IX_SPD_POS, IX_SPD_NEG: prm_max = SPD_MAX;
			default:                prm_max = TQ_MAX;
		endcase
	endfunction : prm_max

	// saturate a written value into range
	function automatic logic [15:0] prm_sat(input logic [3:0] ix, input logic [15:0] v);
		logic [15:0] hi;
		hi = prm_max(ix);
		if (v > hi)
			prm_sat = hi;
		else if ((ix == IX_F1_FC || ix == IX_F2_FC) && v < FC_MIN)
			prm_sat = FC_MIN;
		else
			prm_sat = v;
	endfunction : prm_sat

endpackage : trc_pkg
